// File: common/pwm_consts.svh
// Purpose: numeric constants of the serial programmed pulse modulator
// Assumes: included by bare name after the package
// Notes: definitions only
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH

// data register width and serial word
`define SPW_REG_W 8
`define SPW_WORD_W 24
`define SPW_BITCNT_W 5
`define SPW_BITCNT_MAX 5'h1F

// legal write lengths in bits
`define SPW_LEN_ONE 5'h08
`define SPW_LEN_TWO 5'h10
`define SPW_LEN_THREE 5'h18

// byte counts reported with a load
`define SPW_BYTES_ONE 2'h1
`define SPW_BYTES_TWO 2'h2
`define SPW_BYTES_THREE 2'h3

// control register fields
`define SPW_CTRL_DIV_BIT 0
`define SPW_CTRL_PD_BIT 1

// byte positions inside the shifted word
`define SPW_CTRL_HI 23
`define SPW_CTRL_LO 16
`define SPW_FREQ_HI 15
`define SPW_FREQ_LO 8
`define SPW_PW_HI 7
`define SPW_PW_LO 0

// register reset values
`define SPW_CTRL_RST 8'h00
`define SPW_FREQ_RST 8'h00
`define SPW_PW_RST 8'h00

`endif

// File: common/pwm_pkg.sv
// Purpose: types shared by the serial programmed pulse modulator files
// Assumes: widths match pwm_consts.svh
// Notes: no constants here, only types
package pwm_pkg;

    // one load handed from the serial front end at deselection
    typedef struct packed {
        logic strobe;
        logic [1:0] bytes;
        logic [23:0] word;
    } load_s;

    // state of the serial front end
    typedef struct packed {
        logic csPrev;
        logic sckPrev;
        logic [23:0] shift;
        logic [4:0] bitCnt;
        load_s load;
    } serial_state_s;

    // recovery from a threshold trip
    typedef enum logic [2:0] {
        TRIP_IDLE = 3'b001,
        TRIP_HOLD = 3'b010,
        TRIP_ARMED = 3'b100
    } trip_e;

    // state of the modulator core
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] freq;
        logic [7:0] pw;
        logic configured;
        logic running;
        logic [7:0] actFreq;
        logic [7:0] actPw;
        logic actDiv;
        logic srcPrev;
        logic prescale;
        logic [7:0] cnt;
        trip_e trip;
        logic tripFlag;
        logic pwmOut;
    } pwm_state_s;

endpackage

// File: logic/serial_shift_capture.sv
// Purpose: serial write port; shifts bits in and reports a load at deselection
// Assumes: chip select, serial clock and data are synchronous to ref_clk
// Notes: serial clock must be slower than half of ref_clk to be seen
`include "pwm_consts.svh"

module serial_shift_capture (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial pins
    input wire logic csN,
    input wire logic sck,
    input wire logic sdata,
    // load towards the core, one-cycle strobe
    output pwm_pkg::load_s load
);

    pwm_pkg::serial_state_s st_r;
    pwm_pkg::serial_state_s st_nxt;

    always_comb begin
        logic selected;
        logic sckRise;
        logic csRise;
        logic csFall;
        selected = 1'b0;
        sckRise = 1'b0;
        csRise = 1'b0;
        csFall = 1'b0;
        st_nxt = st_r;
        selected = ~csN;
        sckRise = sck & ~st_r.sckPrev;
        csRise = csN & ~st_r.csPrev;
        csFall = ~csN & st_r.csPrev;
        st_nxt.csPrev = csN;
        st_nxt.sckPrev = sck;
        st_nxt.load.strobe = 1'b0;
        if (csFall) begin
            st_nxt.bitCnt = '0; // [RL2]
        end
        if (selected && sckRise) begin
            // msb first: each bit enters at the bottom and moves up
            st_nxt.shift = {st_r.shift[`SPW_WORD_W-2:0], sdata}; // [RL6]
            if (st_r.bitCnt != `SPW_BITCNT_MAX) begin
                st_nxt.bitCnt = st_r.bitCnt + 5'h01;
            end
        end
        if (csRise) begin
            st_nxt.load.word = st_r.shift; // [RL3]
            unique case (st_r.bitCnt)
                `SPW_LEN_ONE: begin
                    st_nxt.load.strobe = 1'b1; // [RL8]
                    st_nxt.load.bytes = `SPW_BYTES_ONE;
                end
                `SPW_LEN_TWO: begin
                    st_nxt.load.strobe = 1'b1;
                    st_nxt.load.bytes = `SPW_BYTES_TWO;
                end
                `SPW_LEN_THREE: begin
                    st_nxt.load.strobe = 1'b1;
                    st_nxt.load.bytes = `SPW_BYTES_THREE;
                end
                default: begin
                    // odd lengths are dropped without touching registers
                    st_nxt.load.strobe = 1'b0; // [RL17]
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '{csPrev: 1'b1, sckPrev: 1'b0, shift: '0, bitCnt: '0,
                      load: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign load = st_r.load;

endmodule

// File: logic/serial_programmed_pwm.sv
// Purpose: pulse modulator that divides a sampled source clock, programmed serially
// Assumes: all inputs synchronous to ref_clk; source clock below half of ref_clk
// Notes: threshold comparator is outside; it gives two digital levels
//
// Contract
// (RL1) output derived from source clock, divided by one or two per divider bit
// (RL2) chip select falling selects device and starts a serial write
// (RL3) chip select rising deselects and copies shift register into data registers
// (RL4) sense above upper threshold forces output low immediately
// (RL5) after trip, low until sense below lower, deselect, and register rewrite
// (RL6) serial data sampled on rising serial clock, shifted msb first
// (RL7) after power-up output low until select, 24 bits, deselect
// (RL8) writes are 8, 16 or 24 bits msb first, all accepted
// (RL9) host keeps serial clock low while idle, mode 0,0
// (RL10) host raises chip select after every write
// (RL11) output frequency and duty set by control, frequency, pulse width registers
// (RL12) 24 bits: control, frequency, width; 16: frequency, width; 8: width
// (RL13) period is (N+1)(divider+1) source clocks, N from frequency register
// (RL14) high for (N+1)(divider+1) source clocks at period start, N from width
// (RL15) new frequency or width takes effect after the current period ends
// (RL16) power-down stops clocking, holds output low; left only by 24-bit write
// (RL17) writes of other lengths leave registers unchanged
`include "pwm_consts.svh"

module serial_programmed_pwm (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // pulse source clock, sampled
    input wire logic srcClk,
    // serial write port
    input wire logic csN,
    input wire logic sck,
    input wire logic sdata,
    // threshold comparator levels
    input wire logic senseAboveUpper,
    input wire logic senseBelowLower,
    // pulse output
    output logic pwmOut,
    // status
    output logic configured,
    output logic running,
    output logic powerDown,
    output logic tripped,
    // register contents
    output logic [7:0] ctrlReg,
    output logic [7:0] freqReg,
    output logic [7:0] pwReg
);

    pwm_pkg::load_s load;
    pwm_pkg::pwm_state_s st_r;
    pwm_pkg::pwm_state_s st_nxt;

    // control bit decodes, shared by the start, wrap and status paths
    function automatic logic div_sel(input logic [7:0] c);
        return c[`SPW_CTRL_DIV_BIT];
    endfunction

    function automatic logic pd_sel(input logic [7:0] c);
        return c[`SPW_CTRL_PD_BIT];
    endfunction

    // copy programmed values into the working copy that the counter uses
    function automatic pwm_pkg::pwm_state_s take_shadow(input pwm_pkg::pwm_state_s s);
        pwm_pkg::pwm_state_s r;
        r = s;
        r.actFreq = s.freq;
        r.actPw = s.pw;
        r.actDiv = div_sel(s.ctrl);
        return r;
    endfunction

    serial_shift_capture u_serial (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .csN(csN),
        .sck(sck),
        .sdata(sdata),
        .load(load)
    );

    always_comb begin
        logic srcRise;
        logic tick;
        logic pdNext;
        logic loadOk;
        srcRise = 1'b0;
        tick = 1'b0;
        pdNext = 1'b0;
        loadOk = 1'b0;
        st_nxt = st_r;

        // register loads at deselection; bytes map by write length
        if (load.strobe) begin
            unique case (load.bytes)
                `SPW_BYTES_THREE: begin
                    st_nxt.ctrl = load.word[`SPW_CTRL_HI:`SPW_CTRL_LO]; // [RL12]
                    st_nxt.freq = load.word[`SPW_FREQ_HI:`SPW_FREQ_LO];
                    st_nxt.pw = load.word[`SPW_PW_HI:`SPW_PW_LO];
                    st_nxt.configured = 1'b1; // [RL7]
                end
                `SPW_BYTES_TWO: begin
                    st_nxt.freq = load.word[`SPW_FREQ_HI:`SPW_FREQ_LO]; // [RL12]
                    st_nxt.pw = load.word[`SPW_PW_HI:`SPW_PW_LO];
                end
                `SPW_BYTES_ONE: begin
                    st_nxt.pw = load.word[`SPW_PW_HI:`SPW_PW_LO]; // [RL12]
                end
                default: begin
                    // a strobe never comes with a zero byte count
                    st_nxt.pw = st_r.pw;
                end
            endcase
        end
        loadOk = load.strobe;
        // control only changes on a 24-bit load, so only that can clear it
        pdNext = pd_sel(st_nxt.ctrl); // [RL16]

        // source clock edge and divide-by-one or divide-by-two prescale
        st_nxt.srcPrev = srcClk;
        // a source clock above half of ref_clk would lose edges here
        srcRise = srcClk & ~st_r.srcPrev;
        if (srcRise && st_r.running && !pdNext) begin
            if (st_r.actDiv) begin
                st_nxt.prescale = ~st_r.prescale; // [RL1]
                tick = st_r.prescale;
            end else begin
                tick = 1'b1; // [RL1]
            end
        end

        // period counter; shadowed values swap in only at a period boundary
        if (tick) begin
            if (st_r.cnt == st_r.actFreq) begin
                st_nxt.cnt = '0; // [RL13]
                st_nxt = take_shadow(st_nxt); // [RL15]
            end else begin
                st_nxt.cnt = st_r.cnt + 8'h01;
            end
        end

        // power-down halts counting; a clearing 24-bit load restarts cleanly
        if (pdNext) begin
            st_nxt.running = 1'b0; // [RL16]
            st_nxt.prescale = 1'b0;
            st_nxt.cnt = '0;
        end else if (loadOk && !st_r.running && st_nxt.configured) begin
            // nothing in progress, so the first period starts at deselection
            st_nxt.running = 1'b1; // [RL7]
            st_nxt.cnt = '0;
            st_nxt.prescale = 1'b0;
            st_nxt = take_shadow(st_nxt);
        end

        // threshold trip recovery
        unique case (st_r.trip)
            pwm_pkg::TRIP_IDLE: begin
                if (senseAboveUpper) begin
                    st_nxt.trip = pwm_pkg::TRIP_HOLD; // [RL4]
                end
            end
            pwm_pkg::TRIP_HOLD: begin
                // both levels looked at so a crossed comparator pair cannot arm
                if (senseBelowLower && !senseAboveUpper) begin
                    st_nxt.trip = pwm_pkg::TRIP_ARMED; // [RL5]
                end
            end
            pwm_pkg::TRIP_ARMED: begin
                if (senseAboveUpper) begin
                    st_nxt.trip = pwm_pkg::TRIP_HOLD;
                end else if (loadOk) begin
                    // the load arrives only with a deselection
                    st_nxt.trip = pwm_pkg::TRIP_IDLE; // [RL5]
                end
            end
            default: begin
                // an illegal code is treated as a trip, the safe side
                st_nxt.trip = pwm_pkg::TRIP_HOLD;
            end
        endcase

        // registered so the status pin leaves a flip-flop
        st_nxt.tripFlag = (st_nxt.trip != pwm_pkg::TRIP_IDLE);

        // output is built from next state so it leaves a flip-flop
        // a width at or above the period gives a constant high level
        st_nxt.pwmOut = st_nxt.running && !pdNext && !senseAboveUpper // [RL4]
            && (st_nxt.trip == pwm_pkg::TRIP_IDLE) // [RL5]
            && (st_nxt.cnt <= st_nxt.actPw); // [RL14] [RL11]
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '{
                ctrl: `SPW_CTRL_RST,
                freq: `SPW_FREQ_RST,
                pw: `SPW_PW_RST,
                configured: 1'b0,
                running: 1'b0,
                actFreq: '0,
                actPw: '0,
                actDiv: 1'b0,
                srcPrev: 1'b0,
                prescale: 1'b0,
                cnt: '0,
                trip: pwm_pkg::TRIP_IDLE,
                tripFlag: 1'b0,
                pwmOut: 1'b0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pwmOut = st_r.pwmOut;
    assign configured = st_r.configured;
    assign running = st_r.running;
    assign powerDown = pd_sel(st_r.ctrl);
    assign tripped = st_r.tripFlag;
    assign ctrlReg = st_r.ctrl;
    assign freqReg = st_r.freq;
    assign pwReg = st_r.pw;

endmodule

// File: test/pwm_check_sva.sv
// Purpose: port checks for serial_programmed_pwm
// Assumes: bound to the top module; one clock domain
// Notes: a shadow bit count and shift word mirror the serial port
module pwm_check (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial and sense inputs
    input wire logic csN,
    input wire logic sck,
    input wire logic sdata,
    input wire logic senseAboveUpper,
    // outputs
    input wire logic pwmOut,
    input wire logic configured,
    input wire logic running,
    input wire logic powerDown,
    input wire logic tripped,
    input wire logic [7:0] ctrlReg,
    input wire logic [7:0] freqReg,
    input wire logic [7:0] pwReg
);
    timeunit 1ns;
    timeprecision 1ps;
    logic csPrev_r;
    logic sckPrev_r;
    logic [4:0] cnt_r;
    logic [23:0] sh_r;
    logic lenOk;
    assign lenOk = cnt_r == 5'h08 || cnt_r == 5'h10 || cnt_r == 5'h18;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            csPrev_r <= 1'b1;
            sckPrev_r <= 1'b0;
            cnt_r <= 5'h00;
            sh_r <= 24'h000000;
        end else begin
            csPrev_r <= csN;
            sckPrev_r <= sck;
            if (csPrev_r && !csN) begin
                cnt_r <= 5'h00;
            end else if (!csN && sck && !sckPrev_r) begin
                // saturate so an overlong write never wraps to a legal count
                cnt_r <= (cnt_r == 5'h1F) ? cnt_r : cnt_r + 5'h01;
                sh_r <= {sh_r[22:0], sdata};
            end
        end
    end
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_trip_forces_low: assert property (senseAboveUpper |=> !pwmOut && tripped)
        else $error("output not low after trip");
    chk_trip_holds_low: assert property (tripped |-> !pwmOut)
        else $error("output high while tripped");
    chk_trip_clear_load: assert property ($fell(tripped) |-> $past(csN, 2) && !$past(csN, 3))
        else $error("trip cleared without deselect");
    chk_unconfig_low: assert property (!configured |-> !pwmOut)
        else $error("output high before full load");
    chk_pd_holds_low: assert property (powerDown && $past(powerDown) |-> !pwmOut && !running)
        else $error("output active in power down");
    chk_hold_while_sel: assert property (!csN [*4] |-> $stable({ctrlReg, freqReg, pwReg}))
        else $error("registers moved while selected");
    chk_ctrl_full_only: assert property ($changed(ctrlReg) |-> cnt_r == 5'h18)
        else $error("control changed by short write");
    chk_freq_len: assert property ($changed(freqReg) |-> cnt_r == 5'h10 || cnt_r == 5'h18)
        else $error("frequency changed by bad length");
    chk_pw_data: assert property ($rose(csN) && lenOk |-> ##2 pwReg == sh_r[7:0])
        else $error("width register wrong after load");
    chk_full_data: assert property ($rose(csN) && cnt_r == 5'h18
        |-> ##2 ctrlReg == sh_r[23:16] && freqReg == sh_r[15:8])
        else $error("full load put bytes in wrong order");
    cover property ($rose(pwmOut));
    cover property ($rose(tripped));
    cover property ($changed(ctrlReg));
endmodule

// File: test/host_model.sv
// Purpose: serial master standing in for the host controller
// Assumes: device samples the pins on ref_clk rising edges
// Notes: each serial clock high level lasts two ref_clk cycles, each low level three
module host_model (
    // clock
    input wire logic ref_clk,
    // serial pins towards the device
    output logic csN,
    output logic sck,
    output logic sdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        sdata = 1'b0;
    end
    // sends the low n bits of w, most significant first
    task automatic send(input logic [23:0] w, input logic [4:0] n);
        @(negedge ref_clk) csN <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge ref_clk) sdata <= w[i];
            repeat (2) @(negedge ref_clk);
            sck <= 1'b1;
            repeat (2) @(negedge ref_clk);
            sck <= 1'b0;
        end
        repeat (2) @(negedge ref_clk);
        csN <= 1'b1;
        // released data line must not look held
        sdata <= ~sdata;
        repeat (3) @(negedge ref_clk);
    endtask
endmodule

// File: test/testbench.sv
// Purpose: self-checking bench for serial_programmed_pwm
// Assumes: source clock ticks every fourth ref_clk cycle
// Notes: expected widths are in ref_clk cycles, four per tick
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [23:0] w;
        logic [4:0] n;
        logic [23:0] e;
        int hi;
        int per;
    } row_s;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic srcClk = 1'b0;
    logic senseAboveUpper = 1'b0;
    logic senseBelowLower = 1'b0;
    logic csN, sck, sdata, pwmOut, configured, running, powerDown, tripped;
    logic [7:0] ctrlReg, freqReg, pwReg;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int hi, per;
    row_s rows[5] = '{
        '{24'h000401, 5'h18, 24'h000401, 8, 20},
        '{24'h000003, 5'h08, 24'h000403, 16, 20},
        '{24'h000502, 5'h10, 24'h000502, 12, 24},
        '{24'h010201, 5'h18, 24'h010201, 16, 24},
        '{24'h000100, 5'h18, 24'h000100, 4, 8}
    };
    host_model host_u (.ref_clk, .csN, .sck, .sdata);
    serial_programmed_pwm dut_u (.ref_clk, .rst_n, .srcClk, .csN, .sck, .sdata,
        .senseAboveUpper, .senseBelowLower, .pwmOut, .configured, .running,
        .powerDown, .tripped, .ctrlReg, .freqReg, .pwReg);
    initial forever #2 ref_clk = ~ref_clk;
    initial forever begin
        repeat (2) @(negedge ref_clk);
        srcClk = ~srcClk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask
    // skips two rising edges so the period in flight is never measured
    task automatic meas(output int h, output int p);
        int k;
        h = 0;
        repeat (2) begin
            for (k = 0; k < 300 && pwmOut !== 1'b0; k++) @(negedge ref_clk);
            for (k = 0; k < 300 && pwmOut !== 1'b1; k++) @(negedge ref_clk);
        end
        while (pwmOut === 1'b1 && h < 300) begin
            h++;
            @(negedge ref_clk);
        end
        p = h;
        while (pwmOut === 1'b0 && p < 300) begin
            p++;
            @(negedge ref_clk);
        end
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        chk("after reset", 24'h000000, {ctrlReg, freqReg, pwReg});
        host_u.send(24'h000007, 5'h08);
        repeat (20) @(negedge ref_clk);
        chk("pw only", 24'h000007, {ctrlReg, freqReg, pwReg});
        chk("unconfigured", 24'h000000, 24'({configured, pwmOut}));
        foreach (rows[i]) begin
            host_u.send(rows[i].w, rows[i].n);
            meas(hi, per);
            chk("regs", rows[i].e, {ctrlReg, freqReg, pwReg});
            chk("high time", 24'(rows[i].hi), 24'(hi));
            chk("period", 24'(rows[i].per), 24'(per));
        end
        host_u.send(24'h000FFF, 5'h0C);
        repeat (4) @(negedge ref_clk);
        chk("odd length", rows[4].e, {ctrlReg, freqReg, pwReg});
        for (int k = 0; k < 50 && pwmOut !== 1'b1; k++) @(negedge ref_clk);
        senseAboveUpper = 1'b1;
        @(negedge ref_clk);
        chk("trip", 24'h000001, 24'({pwmOut, tripped}));
        host_u.send(24'h000000, 5'h08);
        senseAboveUpper = 1'b0;
        senseBelowLower = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("trip held", 24'h000001, 24'({pwmOut, tripped}));
        host_u.send(24'h000000, 5'h08);
        senseBelowLower = 1'b0;
        meas(hi, per);
        chk("recovered", 24'h000004, 24'(hi));
        host_u.send(24'h020401, 5'h18);
        repeat (30) @(negedge ref_clk);
        chk("power down", 24'h000004, 24'({powerDown, running, pwmOut}));
        host_u.send(24'h000003, 5'h10);
        repeat (30) @(negedge ref_clk);
        chk("still down", 24'h000004, 24'({powerDown, running, pwmOut}));
        host_u.send(24'h000401, 5'h18);
        meas(hi, per);
        chk("restart high", 24'h000008, 24'(hi));
        chk("restart period", 24'h000014, 24'(per));
        // long period, then a width change in mid-period must wait for the wrap
        host_u.send(24'h00403F, 5'h18);
        for (int k = 0; k < 300 && pwmOut !== 1'b0; k++) @(negedge ref_clk);
        for (int k = 0; k < 300 && pwmOut !== 1'b1; k++) @(negedge ref_clk);
        host_u.send(24'h000000, 5'h08);
        chk("old width kept", 24'h000001, 24'(pwmOut));
        chk("new width reg", 24'h000000, 24'(pwReg));
        meas(hi, per);
        chk("new width", 24'h000004, 24'(hi));
        chk("long period", 24'h000104, 24'(per));
        tally_and_finish();
    end
endmodule

bind serial_programmed_pwm pwm_check chk_u (.ref_clk, .rst_n, .csN, .sck, .sdata,
    .senseAboveUpper, .pwmOut, .configured, .running, .powerDown, .tripped,
    .ctrlReg, .freqReg, .pwReg);
